/* dv/tb_top.sv */
// self-checking bench for the timer compare and flag unit
`timescale 1ns/1ps
module tb_top;
   import tcf_pkg::*;
   logic        pclk;
   logic        presetn;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe_n;
   logic        irq;
   logic [31:0] rv;
   logic        re;
   logic [7:0]  h;
   int          num_errors;
   int          tests_run;

   tcf_top #(.NCH(8)) u_tcf_top (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_pin_in(pin_in), .timer_pin_out(pin_out),
      .timer_pin_oe_n(pin_oe_n), .irq(irq)
   );

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until pready is seen high with psel and penable
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         wrap_up();
      end
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      apb({i, 2'h0}, 1'b1, d);
   endtask

   task automatic rd(input logic [5:0] i, input logic [31:0] e);
      apb({i, 2'h0}, 1'b0, 32'h0);
      chk(rv, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // outputs are looked at mid-cycle, after the edge's updates land
   task automatic pins(input logic [7:0] o, input logic [7:0] oe,
                       input logic q);
      @(negedge pclk);
      chk({15'h0, irq, pin_oe_n, pin_out}, {15'h0, q, oe, o});
   endtask
   ////////////////////////////////////////////////////////////////////
   // reset values, counter held
   task automatic t_reset;
      pins(8'h00, 8'hff, 1'b0);
      rd(REG_CNT_HI_IDX, 32'h0);
      rd(REG_CNT_LO_IDX, 32'h0);
   endtask

   task automatic t_wrap;
      wr(REG_CNT_HI_IDX, 32'hff);
      wr(REG_CNT_LO_IDX, 32'hf0);
      cyc(5);
      rd(REG_CNT_HI_IDX, 32'hff);
      rd(REG_CNT_LO_IDX, 32'hf0);
      wr(REG_CTRL_IDX, 32'h80);
      apb({REG_CNT_LO_IDX, 2'h0}, 1'b0, 32'h0);
      h = rv[7:0];
      rd(REG_CNT_LO_IDX, {24'h0, h + 8'h3});
      cyc(40);
      pins(8'h00, 8'hff, 1'b0);
      rd(REG_OVFLAG_IDX, 32'h80);
      rd(REG_CNT_HI_IDX, 32'h0);
      wr(REG_OVFLAG_IDX, 32'h7f);
      rd(REG_OVFLAG_IDX, 32'h80);
      wr(REG_OVFLAG_IDX, 32'h80);
      rd(REG_OVFLAG_IDX, 32'h0);
      wr(REG_IRQ_MASK_IDX, 32'h100);
      pins(8'h00, 8'hff, 1'b1);
      rd(REG_IRQ_STAT_IDX, 32'h100);
      pins(8'h00, 8'hff, 1'b0);
      rd(REG_IRQ_STAT_IDX, 32'h0);
   endtask

   task automatic t_capture;
      @(posedge pclk);
      pin_in <= 8'h01;
      cyc(8);
      rd(REG_CHFLAG_IDX, 32'h01);
      wr(REG_CHFLAG_IDX, 32'hfe);
      rd(REG_CHFLAG_IDX, 32'h01);
      wr(REG_CTRL_IDX, 32'h00);
      wr(REG_CHFLAG_IDX, 32'h01);
      rd(REG_CHFLAG_IDX, 32'h01);
      wr(REG_CTRL_IDX, 32'h90);
      wr(REG_CHFLAG_IDX, 32'h01);
      rd(REG_CHFLAG_IDX, 32'h00);
      @(posedge pclk);
      pin_in <= 8'h00;
      cyc(4);
      pin_in <= 8'h01;
      cyc(8);
      rd(REG_CHFLAG_IDX, 32'h01);
      apb({REG_CHAN_BASE_IDX, 2'h0}, 1'b0, 32'h0);
      rd(REG_CHFLAG_IDX, 32'h00);
   endtask

   // with fast clear on, a counter access clears the wrap flag
   task automatic t_fastovf;
      wr(REG_CNT_LO_IDX, 32'h00);
      wr(REG_CNT_HI_IDX, 32'hff);
      wr(REG_CNT_LO_IDX, 32'hf0);
      cyc(40);
      rd(REG_OVFLAG_IDX, 32'h80);
      apb({REG_CNT_LO_IDX, 2'h0}, 1'b0, 32'h0);
      rd(REG_OVFLAG_IDX, 32'h00);
      rd(REG_IRQ_STAT_IDX, 32'h101);
   endtask

   // channel 7 override of a same-count compare
   task automatic t_compare;
      wr(REG_SELECT_IDX, 32'h86);
      wr(REG_MASK_IDX, 32'h0c);
      wr(REG_DATA_IDX, 32'h08);
      pins(8'h00, 8'h7b, 1'b0);
      apb({REG_CNT_HI_IDX, 2'h0}, 1'b0, 32'h0);
      h = rv[7:0];
      wr(REG_CHAN_BASE_IDX + 6'h2, {24'h0, h + 8'h2});
      wr(REG_CHAN_BASE_IDX + 6'h4, {24'h0, h + 8'h3});
      wr(REG_CHAN_BASE_IDX + 6'he, {24'h0, h + 8'h3});
      cyc(900);
      rd(REG_CHFLAG_IDX, 32'h86);
      pins(8'h8a, 8'h7b, 1'b0);
      wr(REG_CHAN_BASE_IDX + 6'h3, 32'h0);
      rd(REG_CHFLAG_IDX, 32'h84);
   endtask

   task automatic t_errors;
      apb({6'h01, 2'h0}, 1'b0, 32'h0);
      chk({31'h0, re}, 32'h1);
      chk(rv, 32'h0);
      apb({REG_CTRL_IDX, 2'h1}, 1'b1, 32'h0);
      chk({31'h0, re}, 32'h1);
      rd(REG_CTRL_IDX, 32'h90);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      paddr = 8'h00;
      pwrite = 1'b0;
      pwdata = 32'h0;
      pin_in = 8'h00;
      num_errors = 0;
      tests_run = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_wrap();
      t_capture();
      t_fastovf();
      t_compare();
      t_errors();
      wrap_up();
   end
endmodule

bind tcf_top tcf_sva_chk #(.NCH(NCH)) u_tcf_sva_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
   .timer_pin_oe_n(timer_pin_oe_n), .irq(irq)
);

/* dv/tcf_top_assertions.sv */
// concurrent checks on the bus and pin ports of the timer unit
`timescale 1ns/1ps
module tcf_sva_chk #(
   parameter int NCH = 8
) (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic [tcf_pkg::ADDR_W-1:0] paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [NCH-1:0]             timer_pin_in,
   input wire logic [NCH-1:0]             timer_pin_out,
   input wire logic [NCH-1:0]             timer_pin_oe_n,
   input wire logic                       irq
);
   import tcf_pkg::*;
   logic acc;
   logic bad;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   assign acc = psel && penable;
   // holes in the map: index 1, 7 to 0x0d and above the irq mask
   assign bad = paddr[7:2] == 6'h01 || paddr[7:2] > REG_IRQ_MASK_IDX ||
                (paddr[7:2] >= 6'h07 && paddr[7:2] <= 6'h0d);
   ////////////////////////////////////////////////////////////////////
   ready_tied_a: assert property (pready)
      else $error("pready low");
   err_in_access_a: assert property (pslverr |-> acc)
      else $error("pslverr outside access");
   err_unaligned_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   err_unmapped_a: assert property (acc && bad |-> pslverr)
      else $error("unmapped access not refused");
   ok_mapped_a: assert property (acc && !bad && paddr[1:0] == 2'h0
                                 |-> !pslverr)
      else $error("mapped access refused");
   err_read_zero_a: assert property (acc && !pwrite && pslverr
                                     |-> prdata == 32'h0)
      else $error("refused read not zero");
   rdata_hold_a: assert property (psel && !penable && pwrite
                                  |=> $stable(prdata))
      else $error("read data moved during write");
   oe_by_write_a: assert property (!$stable(timer_pin_oe_n)
                                   |-> $past(acc && pwrite))
      else $error("pin direction moved without write");
   irq_fall_a: assert property ($fell(irq) |-> $past(acc))
      else $error("irq fell without access");
   wr_c: cover property (acc && pwrite);
   err_c: cover property (acc && pslverr);
   irq_c: cover property ($rose(irq));
   oe_c: cover property ($fell(timer_pin_oe_n[2]));
endmodule

/* hw/tcf_chan_if.sv */
// signals between the register side and the channel compare logic
`timescale 1ns/1ps
interface tcf_chan_if #(parameter int NCH = 8);
   import tcf_pkg::*;
   logic              enable;
   tcf_word_t         count;
   logic [NCH-1:0]    select;
   logic [NCH-1:0]    mask;
   logic [NCH-1:0]    odata;
   logic [NCH-1:0]    pin;
   tcf_word_t         value [NCH];
   logic [NCH-1:0]    cmp_hit;
   logic [NCH-1:0]    cap_hit;
   logic [NCH-1:0]    port_q;
   logic [NCH-1:0]    port_oe_n;

   modport regs (output enable, count, select, mask, odata, pin, value,
                 input  cmp_hit, cap_hit, port_q, port_oe_n);
   modport unit (input  enable, count, select, mask, odata, pin, value,
                 output cmp_hit, cap_hit, port_q, port_oe_n);
endinterface

/* hw/tcf_compare.sv */
// per-channel compare and capture detect, port data and pin drive
`timescale 1ns/1ps
module tcf_compare #(parameter int NCH = 8) (
   input  wire logic pclk,
   input  wire logic presetn,
   tcf_chan_if.unit  ch
);
   import tcf_pkg::*;

   logic [NCH-1:0] pin_prev_reg;
   logic [NCH-1:0] port_reg;
   logic [NCH-1:0] port_next;

   generate
      for (genvar i = 0; i < NCH; i++) begin : g_ch
         assign ch.cmp_hit[i] = ch.enable & ch.select[i] &
                                (ch.count == ch.value[i]);
         assign ch.cap_hit[i] = ch.enable & ~ch.select[i] &
                                ch.pin[i] & ~pin_prev_reg[i];
         // pin drives when masked compare, channel 7 on its own select
         if (i == NCH - 1) begin : g_top
            assign ch.port_oe_n[i] = ~ch.select[i];
         end else begin : g_low
            assign ch.port_oe_n[i] = ~(ch.select[i] & ch.mask[i]);
         end
      end
   endgenerate

   assign ch.port_q = port_reg;

   always_comb begin
      // a plain compare toggles its own port bit
      port_next = port_reg ^ ch.cmp_hit;
      if (ch.cmp_hit[NCH-1]) begin
         port_next = (port_next & ~ch.mask) | (ch.odata & ch.mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_reg <= '0;
      end else begin
         pin_prev_reg <= ch.pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_reg <= '0;
      end else begin
         port_reg <= port_next;
      end
   end
endmodule

/* hw/tcf_counter.sv */
// free-running counter with byte writes and wrap detect
`timescale 1ns/1ps
module tcf_counter #(parameter int W = 16) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         enable,
   input  wire logic         wr_hi,
   input  wire logic         wr_lo,
   input  wire logic [7:0]   wbyte,
   output logic      [W-1:0] count,
   output logic              wrap
);
   import tcf_pkg::*;

   logic [W-1:0] count_reg;

   assign count = count_reg;
   assign wrap  = enable & ~wr_hi & ~wr_lo & (count_reg == COUNT_MAX);

   // software write wins over the increment in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= RST_COUNT;
      end else if (wr_hi) begin
         count_reg <= {wbyte, count_reg[7:0]};
      end else if (wr_lo) begin
         count_reg <= {count_reg[W-1:8], wbyte};
      end else if (enable) begin
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule

/* hw/tcf_pkg.sv */
// shared constants of the timer compare and flag unit
package tcf_pkg;

   // register indices; byte address is four times the index
   localparam int          ADDR_W            = 8;
   localparam logic [5:0]  REG_SELECT_IDX    = 6'h00;
   localparam logic [5:0]  REG_MASK_IDX      = 6'h02;
   localparam logic [5:0]  REG_DATA_IDX      = 6'h03;
   localparam logic [5:0]  REG_CNT_HI_IDX    = 6'h04;
   localparam logic [5:0]  REG_CNT_LO_IDX    = 6'h05;
   localparam logic [5:0]  REG_CTRL_IDX      = 6'h06;
   localparam logic [5:0]  REG_CHFLAG_IDX    = 6'h0e;
   localparam logic [5:0]  REG_OVFLAG_IDX    = 6'h0f;
   localparam logic [5:0]  REG_CHAN_BASE_IDX = 6'h10;
   localparam logic [5:0]  REG_CHAN_LAST_IDX = 6'h1f;
   localparam logic [5:0]  REG_IRQ_STAT_IDX  = 6'h20;
   localparam logic [5:0]  REG_IRQ_MASK_IDX  = 6'h21;

   // field positions
   localparam int          CTRL_ENABLE_BIT   = 7;
   localparam int          CTRL_FAST_CLR_BIT = 4;
   localparam int          OVF_FLAG_BIT      = 7;
   localparam int          IRQ_OVF_BIT       = 8;
   localparam int          IRQ_W             = 9;

   // reset values and limits
   localparam logic [7:0]  RST_BYTE          = 8'h00;
   localparam logic [15:0] RST_COUNT         = 16'h0000;
   localparam logic [15:0] COUNT_MAX         = 16'hffff;
   localparam logic [IRQ_W-1:0] RST_IRQ      = 9'h000;

   typedef logic [15:0] tcf_word_t;

endpackage

/* hw/tcf_top.sv */
// timer compare and flag unit: apb registers, flags and interrupt
`timescale 1ns/1ps
module tcf_top #(
   parameter int NCH = 8
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic [tcf_pkg::ADDR_W-1:0] paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic [NCH-1:0]             timer_pin_in,
   output logic      [NCH-1:0]             timer_pin_out,
   output logic      [NCH-1:0]             timer_pin_oe_n,
   output logic                            irq
);
   import tcf_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // declarations

   tcf_chan_if #(.NCH(NCH)) ch ();

   logic [NCH-1:0]   pin_meta_reg;
   logic [NCH-1:0]   pin_sync_reg;

   logic [NCH-1:0]   select_reg;
   logic [NCH-1:0]   mask_reg;
   logic [NCH-1:0]   data_reg;
   logic             enable_reg;
   logic             fast_clr_reg;
   logic [NCH-1:0]   chflag_reg;
   logic [NCH-1:0]   chflag_next;
   logic             ovflag_reg;
   logic             ovflag_next;
   tcf_word_t        value_reg [NCH];
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [31:0]      prdata_reg;

   logic [5:0]       idx;
   logic             mapped;
   logic             setup;
   logic             access;
   logic             wr;
   logic             rd;
   logic [7:0]       wbyte;
   logic [31:0]      rd_mux;

   tcf_word_t        count;
   logic             wrap;
   logic             cnt_access;
   logic [NCH-1:0]   chflag_clr;
   logic [NCH-1:0]   chflag_set;
   logic [NCH-1:0]   fast_clr;
   logic [IRQ_W-1:0] irq_events;

   ////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic reg_mapped(input logic [5:0] i);
      reg_mapped = (i == REG_SELECT_IDX)   || (i == REG_MASK_IDX)     ||
                   (i == REG_DATA_IDX)     || (i == REG_CNT_HI_IDX)   ||
                   (i == REG_CNT_LO_IDX)   || (i == REG_CTRL_IDX)     ||
                   (i == REG_CHFLAG_IDX)   || (i == REG_OVFLAG_IDX)   ||
                   (i == REG_IRQ_STAT_IDX) || (i == REG_IRQ_MASK_IDX) ||
                   ((i >= REG_CHAN_BASE_IDX) && (i <= REG_CHAN_LAST_IDX));
   endfunction

   function automatic logic is_chan(input logic [5:0] i,
                                    input int         c);
      is_chan = ((i >= REG_CHAN_BASE_IDX) && (i <= REG_CHAN_LAST_IDX) &&
                 (int'(i[3:1]) == c));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // apb slave

   assign idx     = paddr[ADDR_W-1:2];
   assign mapped  = reg_mapped(idx) && (paddr[1:0] == 2'b00);
   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign wr      = access & pwrite & mapped;
   assign rd      = access & ~pwrite & mapped;
   assign wbyte   = pwdata[7:0];

   // zero wait: read data is latched in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata  = prdata_reg;

   always_comb begin
      rd_mux = '0;
      case (idx)
         REG_SELECT_IDX:   rd_mux[NCH-1:0] = select_reg;
         REG_MASK_IDX:     rd_mux[NCH-1:0] = mask_reg;
         REG_DATA_IDX:     rd_mux[NCH-1:0] = data_reg;
         REG_CNT_HI_IDX:   rd_mux[7:0] = count[15:8];
         REG_CNT_LO_IDX:   rd_mux[7:0] = count[7:0];
         REG_CTRL_IDX: begin
            rd_mux[CTRL_ENABLE_BIT]   = enable_reg;
            rd_mux[CTRL_FAST_CLR_BIT] = fast_clr_reg;
         end
         REG_CHFLAG_IDX:   rd_mux[NCH-1:0] = chflag_reg;
         REG_OVFLAG_IDX:   rd_mux[OVF_FLAG_BIT] = ovflag_reg;
         REG_IRQ_STAT_IDX: rd_mux[IRQ_W-1:0] = irq_stat_reg;
         REG_IRQ_MASK_IDX: rd_mux[IRQ_W-1:0] = irq_mask_reg;
         default: begin
            if (idx >= REG_CHAN_BASE_IDX && idx <= REG_CHAN_LAST_IDX) begin
               if (idx[0] == 1'b0) begin
                  rd_mux[7:0] = value_reg[idx[3:1]][15:8];
               end else begin
                  rd_mux[7:0] = value_reg[idx[3:1]][7:0];
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (setup && !pwrite) begin
         prdata_reg <= mapped ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= timer_pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select_reg   <= RST_BYTE;
         mask_reg     <= RST_BYTE;
         data_reg     <= RST_BYTE;
         enable_reg   <= 1'b0;
         fast_clr_reg <= 1'b0;
         irq_mask_reg <= RST_IRQ;
      end else if (wr) begin
         case (idx)
            REG_SELECT_IDX:   select_reg <= wbyte[NCH-1:0];
            REG_MASK_IDX:     mask_reg   <= wbyte[NCH-1:0];
            REG_DATA_IDX:     data_reg   <= wbyte[NCH-1:0];
            REG_CTRL_IDX: begin
               enable_reg   <= wbyte[CTRL_ENABLE_BIT];
               fast_clr_reg <= wbyte[CTRL_FAST_CLR_BIT];
            end
            REG_IRQ_MASK_IDX: irq_mask_reg <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // counter

   assign cnt_access = (wr | rd) &
                       ((idx == REG_CNT_HI_IDX) || (idx == REG_CNT_LO_IDX));

   tcf_counter #(.W(16)) u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (enable_reg),
      .wr_hi   (wr && (idx == REG_CNT_HI_IDX)),
      .wr_lo   (wr && (idx == REG_CNT_LO_IDX)),
      .wbyte   (wbyte),
      .count   (count),
      .wrap    (wrap)
   );

   ////////////////////////////////////////////////////////////////////
   // channel logic

   assign ch.enable = enable_reg;
   assign ch.count  = count;
   assign ch.select = select_reg;
   assign ch.mask   = mask_reg;
   assign ch.odata  = data_reg;
   assign ch.pin    = pin_sync_reg;

   tcf_compare #(.NCH(NCH)) u_compare (
      .pclk    (pclk),
      .presetn (presetn),
      .ch      (ch.unit)
   );

   assign timer_pin_out  = ch.port_q;
   assign timer_pin_oe_n = ch.port_oe_n;

   // a capture in the same cycle as a write keeps the captured count
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_val
         assign ch.value[c] = value_reg[c];

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               value_reg[c] <= RST_COUNT;
            end else if (ch.cap_hit[c]) begin
               value_reg[c] <= count;
            end else if (wr && is_chan(idx, c)) begin
               if (idx[0] == 1'b0) begin
                  value_reg[c] <= {wbyte, value_reg[c][7:0]};
               end else begin
                  value_reg[c] <= {value_reg[c][15:8], wbyte};
               end
            end
         end

         assign fast_clr[c] = fast_clr_reg && is_chan(idx, c) &&
                              ((rd && !select_reg[c]) ||
                               (wr && select_reg[c]));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // flags

   assign chflag_set = ch.cmp_hit | ch.cap_hit;

   assign chflag_clr = ((wr && idx == REG_CHFLAG_IDX && enable_reg) ?
                        wbyte[NCH-1:0] : '0) | fast_clr;

   // set wins over a clear in the same cycle
   assign chflag_next = (chflag_reg & ~chflag_clr) | chflag_set;

   always_comb begin
      ovflag_next = ovflag_reg;
      if (wr && idx == REG_OVFLAG_IDX && enable_reg &&
          wbyte[OVF_FLAG_BIT]) begin
         ovflag_next = 1'b0;
      end
      if (fast_clr_reg && cnt_access) begin
         ovflag_next = 1'b0;
      end
      if (wrap) begin
         ovflag_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chflag_reg <= RST_BYTE;
         ovflag_reg <= 1'b0;
      end else begin
         chflag_reg <= chflag_next;
         ovflag_reg <= ovflag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt

   assign irq_events = {wrap, chflag_set};

   // read of the status register clears it; new events still land
   // read data was latched in setup, so only the bits it reported are
   // cleared: an event that lands on the setup edge is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= RST_IRQ;
      end else if (rd && idx == REG_IRQ_STAT_IDX) begin
         irq_stat_reg <= (irq_stat_reg & ~prdata_reg[IRQ_W-1:0]) |
                         irq_events;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_events;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule
